// ===== core/fourlic_core.sv
// Four-level nested interrupt controller with the timer and converter flag logic.
// Assumes the core acks only while a request is shown and pulses ret once per handler exit.
//
// Overview of operation
// - Fifteen sources, each assignable to one of four levels.
// - Timer gives eight requests: four capture, three compare, OR of overflows.
// - Capture flags set by capture inputs; compare flags set on count match.
// - Byte overflow sets byte flag; word overflow sets word flag.
// - Hardware never clears the nine timer flags; software must clear them.
// - Converter flag set when result ready, cleared only by software.
// - Two-wire request comes from that unit's serial interrupt flag.
// - Software may clear converter flag; writing one to it does nothing.
// - Other flags software set or clear, acting exactly like hardware events.
// - Each source has its own enable bit; one enables, zero disables.
// - Global enable in first enable register gates every request.
// - Each group has enable, low priority and high priority registers.
// - Level is high bit then low bit; 11 highest, 00 lowest.
// - Pending request waits while equal or higher level is in service.
// - Higher level pre-empts lower service, which resumes afterwards.
// - Fixed polling order breaks ties within one level.
// - Each source vectors to fixed address, eight bytes apart from 0003H.
// - First low priority register holds bits x0,t0,x1,t1,uart,twowire,adc.
module fourlic_core
    import fourlic_pkg::*;
(
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         srst,
    // SFR port from the core
    input  wire fourlic_sfr_t sfr,
    output logic [7:0]        sfr_rdata,
    // Level requests from other units
    input  wire logic         external_request_a,
    input  wire logic         external_request_b,
    input  wire logic         timer0_req,
    input  wire logic         timer1_req,
    input  wire logic         uart_req,
    input  wire logic         twowire_req,
    // Event pulses from timer and converter
    input  wire fourlic_evt_t evt,
    // Handshake with the core
    input  wire logic         irq_ack,
    input  wire logic         irq_ret,
    output fourlic_req_t      irq_out,
    output logic [3:0]        in_service
);

    // ============================================================
    // Helpers
    function automatic logic [NSRC-1:0] map_groups(input logic [6:0] g0, input logic [7:0] g1);
        map_groups = {g1[7], g1[6:4], g0[6], g1[3:0], g0[5:0]};
    endfunction

    function automatic logic [2:0] top_level(input logic [3:0] act);
        top_level = act[3] ? 3'b111 : act[2] ? 3'b110 : act[1] ? 3'b101 :
                    act[0] ? 3'b100 : 3'b000;
    endfunction

    // ============================================================
    // Registers
    logic [7:0] enable_reg_first;
    logic [7:0] enable_reg_second;
    logic [7:0] interrupt_priority_low_group0;
    logic [7:0] priority_high_group0;
    logic [7:0] priority_low_group1;
    logic [7:0] priority_high_group1;
    logic [7:0] timer_flags;
    logic [7:0] timer_ovf_reg;
    logic [7:0] converter_control_reg;

    // ============================================================
    // Address decode
    wire logic wr_enable_reg_first = sfr.wr && (sfr.addr == OFF_ENABLE_REG_FIRST);
    wire logic wr_enable_reg_second = sfr.wr && (sfr.addr == OFF_ENABLE_REG_SECOND);
    wire logic wr_ip0  = sfr.wr && (sfr.addr == OFF_IP0);
    wire logic wr_priority_high_group0 = sfr.wr && (sfr.addr == OFF_PRIORITY_HIGH_GROUP0);
    wire logic wr_ip1  = sfr.wr && (sfr.addr == OFF_IP1);
    wire logic wr_priority_high_group1 = sfr.wr && (sfr.addr == OFF_PRIORITY_HIGH_GROUP1);
    wire logic wr_tmf  = sfr.wr && (sfr.addr == OFF_TMF);
    wire logic wr_tovf = sfr.wr && (sfr.addr == OFF_TOVF);
    wire logic wr_adcc = sfr.wr && (sfr.addr == OFF_ADCC);

    wire logic [7:0] read_mux =
        (sfr.addr == OFF_ENABLE_REG_FIRST) ? enable_reg_first :
        (sfr.addr == OFF_ENABLE_REG_SECOND) ? enable_reg_second :
        (sfr.addr == OFF_IP0)  ? {1'b0, interrupt_priority_low_group0[6:0]} :
        (sfr.addr == OFF_PRIORITY_HIGH_GROUP0) ? {1'b0, priority_high_group0[6:0]} :
        (sfr.addr == OFF_IP1)  ? priority_low_group1 :
        (sfr.addr == OFF_PRIORITY_HIGH_GROUP1) ? priority_high_group1 :
        (sfr.addr == OFF_TMF)  ? timer_flags :
        (sfr.addr == OFF_TOVF) ? timer_ovf_reg :
        (sfr.addr == OFF_ADCC) ? converter_control_reg : 8'h00;

    // ============================================================
    // Flag next values: a hardware set always beats a same-cycle clear
    wire logic [7:0] tm_set = {evt.word_ovf, evt.compare, evt.capture};
    wire logic [7:0] next_timer_flags =
        tm_set | (wr_tmf ? sfr.wdata : timer_flags);
    wire logic [7:0] next_timer_ovf_reg =
        {7'h00, evt.byte_ovf | (wr_tovf ? sfr.wdata[BYTE_OVF_BIT]
                                        : timer_ovf_reg[BYTE_OVF_BIT])};
    // Software can only clear the converter flag, never raise it
    wire logic conv_keep = wr_adcc ? sfr.wdata[CONV_FLAG_BIT] : 1'b1;
    wire logic next_conv_flag =
        evt.conv_done | (converter_control_reg[CONV_FLAG_BIT] & conv_keep);

    // ============================================================
    // Sources in vector order
    wire logic byte_overflow_flag = timer_ovf_reg[BYTE_OVF_BIT];
    wire logic word_overflow_flag = timer_flags[7];
    wire logic [3:0] capture_flag = timer_flags[3:0];
    wire logic [2:0] compare_flag = timer_flags[6:4];
    wire logic converter_complete_flag = converter_control_reg[CONV_FLAG_BIT];
    wire logic global_enable_bit = enable_reg_first[GLOBAL_EN_BIT];

    wire logic [NSRC-1:0] src_pend = {
        byte_overflow_flag | word_overflow_flag,
        compare_flag, converter_complete_flag, capture_flag,
        twowire_req, uart_req, timer1_req, external_request_b,
        timer0_req, external_request_a};
    wire logic [NSRC-1:0] src_en = map_groups(enable_reg_first[6:0], enable_reg_second);
    wire logic [NSRC-1:0] src_lo = map_groups(interrupt_priority_low_group0[6:0],
                                              priority_low_group1);
    wire logic [NSRC-1:0] src_hi = map_groups(priority_high_group0[6:0], priority_high_group1);
    wire logic [2:0] act_top = top_level(in_service);
    wire logic [NSRC-1:0] src_live = src_pend & src_en & {NSRC{global_enable_bit}};

    // ============================================================
    // Arbitration: highest level first, then fixed polling order
    logic       win_found;
    logic [3:0] win_idx;
    logic [1:0] win_lvl;
    always_comb begin
        logic [1:0] lv;
        logic [3:0] p;
        lv = 2'b00;
        p = 4'h0;
        win_found = 1'b0;
        win_idx = 4'h0;
        win_lvl = 2'b00;
        for (int l = NLVL - 1; l >= 0; l--) begin
            for (int k = 0; k < NSRC; k++) begin
                p = POLL_ORDER[k];
                lv = {src_hi[p], src_lo[p]};
                if (!win_found && src_live[p] && (lv == 2'(l)) &&
                    (!act_top[2] || (lv > act_top[1:0]))) begin
                    win_found = 1'b1;
                    win_idx = p;
                    win_lvl = lv;
                end
            end
        end
    end

    wire fourlic_req_t next_irq_out = '{
        req:    win_found && !irq_ack,
        level:  win_lvl,
        vector: VEC_BASE + {9'h000, win_idx, 3'b000}};

    // ============================================================
    // Service tracking: return clears the top level, ack sets the new one
    wire logic [3:0] ret_mask = irq_ret ? (4'b0001 << act_top[1:0]) : 4'h0;
    wire logic [3:0] ack_mask = (irq_ack && irq_out.req) ? (4'b0001 << irq_out.level) : 4'h0;
    wire logic [3:0] next_in_service = (in_service & ~ret_mask) | ack_mask;

    // ============================================================
    // State
    always_ff @(posedge clock) begin
        if (srst) begin
            enable_reg_first <= RST_REG;
            enable_reg_second <= RST_REG;
            interrupt_priority_low_group0 <= RST_REG;
            priority_high_group0 <= RST_REG;
            priority_low_group1 <= RST_REG;
            priority_high_group1 <= RST_REG;
            timer_flags <= RST_REG;
            timer_ovf_reg <= RST_REG;
            converter_control_reg <= RST_REG;
            sfr_rdata <= RST_REG;
            irq_out <= '0;
            in_service <= RST_INSERV;
        end else begin
            if (wr_enable_reg_first) enable_reg_first <= sfr.wdata;
            if (wr_enable_reg_second) enable_reg_second <= sfr.wdata;
            if (wr_ip0) interrupt_priority_low_group0 <= {1'b0, sfr.wdata[6:0]};
            if (wr_priority_high_group0) priority_high_group0 <= {1'b0, sfr.wdata[6:0]};
            if (wr_ip1) priority_low_group1 <= sfr.wdata;
            if (wr_priority_high_group1) priority_high_group1 <= sfr.wdata;
            timer_flags <= next_timer_flags;
            timer_ovf_reg <= next_timer_ovf_reg;
            converter_control_reg <= {3'b000, next_conv_flag, 4'h0};
            sfr_rdata <= sfr.rd ? read_mux : 8'h00;
            irq_out <= next_irq_out;
            in_service <= next_in_service;
        end
    end

    // ============================================================
    // Flag and register checks
    // Per-level view of live requests, read only by the checks
    wire logic [NLVL-1:0] live_lvl = {
        |(src_live & src_hi & src_lo), |(src_live & src_hi & ~src_lo),
        |(src_live & ~src_hi & src_lo), |(src_live & ~src_hi & ~src_lo)};

    a_global_gate: assert property (@(posedge clock) disable iff (srst)
        !global_enable_bit |=> !irq_out.req) else $error("request with global enable off");

    a_flag_hw_set: assert property (@(posedge clock) disable iff (srst)
        evt.capture[2] |=> capture_flag[2]) else $error("capture flag not set");

    a_cmp_hw_set: assert property (@(posedge clock) disable iff (srst)
        evt.compare[0] |=> compare_flag[0]) else $error("compare flag not set");

    a_flag_sticky: assert property (@(posedge clock) disable iff (srst)
        compare_flag[1] && !wr_tmf |=> compare_flag[1]) else $error("timer flag lost");

    a_ovf_request: assert property (@(posedge clock) disable iff (srst)
        evt.byte_ovf ##1 !wr_tovf |=> byte_overflow_flag && src_pend[14])
        else $error("overflow request missing");

    a_word_ovf_set: assert property (@(posedge clock) disable iff (srst)
        evt.word_ovf |=> word_overflow_flag && src_pend[14]) else $error("word overflow lost");

    a_conv_hw_set: assert property (@(posedge clock) disable iff (srst)
        evt.conv_done |=> converter_complete_flag) else $error("converter flag not set");

    a_conv_no_sw_set: assert property (@(posedge clock) disable iff (srst)
        !converter_complete_flag && !evt.conv_done |=> !converter_complete_flag)
        else $error("converter flag set without event");

    a_conv_sw_clear: assert property (@(posedge clock) disable iff (srst)
        wr_adcc && !sfr.wdata[CONV_FLAG_BIT] && !evt.conv_done |=> !converter_complete_flag)
        else $error("converter flag not cleared");

    a_sw_set_flag: assert property (@(posedge clock) disable iff (srst)
        wr_tmf && sfr.wdata[0] ##1 src_en[6] && global_enable_bit && !irq_ack && in_service == 4'h0
        |=> irq_out.req) else $error("software flag gave no request");

    a_sw_clear_flag: assert property (@(posedge clock) disable iff (srst)
        wr_tmf && !sfr.wdata[7] && !evt.word_ovf |=> !word_overflow_flag)
        else $error("software clear ignored");

    a_enable_write: assert property (@(posedge clock) disable iff (srst)
        wr_enable_reg_second |=> enable_reg_second == $past(sfr.wdata)) else $error("enable write lost");

    a_uart_disabled: assert property (@(posedge clock) disable iff (srst)
        !$past(src_en[4]) |-> !(irq_out.req && irq_out.vector == 16'h0023))
        else $error("disabled source shown");

    a_prio_low_map: assert property (@(posedge clock) disable iff (srst)
        wr_ip0 |=> interrupt_priority_low_group0 == {1'b0, $past(sfr.wdata[6:0])})
        else $error("priority byte stored wrong");

    a_rdata_idle: assert property (@(posedge clock) disable iff (srst)
        !sfr.rd |=> sfr_rdata == 8'h00) else $error("read data not cleared");

    // ============================================================
    // Arbitration and handshake checks
    // A lower live level shown while a higher one waits would break nesting
    a_level_first: assert property (@(posedge clock) disable iff (srst)
        irq_out.req |-> ($past(live_lvl) >> irq_out.level) == 4'h1)
        else $error("shown level not the highest live");

    a_first_wins: assert property (@(posedge clock) disable iff (srst)
        irq_out.req && irq_out.level == 2'b00 && $past(src_live[0] && !src_hi[0] && !src_lo[0])
        |-> irq_out.vector == VEC_BASE) else $error("polling order broken");

    a_top_preempt: assert property (@(posedge clock) disable iff (srst)
        in_service == 4'b0001 && src_live[3] && src_hi[3] && src_lo[3] && !irq_ack
        |=> irq_out.req && irq_out.level == 2'b11) else $error("no pre-emption");

    a_ack_drop: assert property (@(posedge clock) disable iff (srst)
        irq_ack && irq_out.req |=> !irq_out.req) else $error("request held after ack");

    a_ack_marks: assert property (@(posedge clock) disable iff (srst)
        irq_ack && irq_out.req && !irq_ret |=> in_service[$past(irq_out.level)])
        else $error("acked level not in service");

    a_ret_resume: assert property (@(posedge clock) disable iff (srst)
        irq_ret && !irq_ack && in_service[3] |=> !in_service[3] &&
        in_service[2:0] == $past(in_service[2:0])) else $error("return lost a level");

    a_preempt_only: assert property (@(posedge clock) disable iff (srst)
        irq_out.req && $past(in_service) == in_service && in_service != 4'h0
        |-> irq_out.level > act_top[1:0]) else $error("request does not outrank service");

    a_vector_map: assert property (@(posedge clock) disable iff (srst)
        irq_out.req |-> irq_out.vector[2:0] == 3'b011 && irq_out.vector < 16'h007b)
        else $error("vector off grid");

    // ============================================================
    // Covers
    c_nested: cover property (@(posedge clock) disable iff (srst)
        in_service[0] && irq_ack && irq_out.req && irq_out.level == 2'b11);
    c_resume: cover property (@(posedge clock) disable iff (srst)
        in_service == 4'b1001 ##1 irq_ret ##1 in_service == 4'b0001);
    c_conv_req: cover property (@(posedge clock) disable iff (srst)
        irq_out.req && irq_out.vector == 16'h0053);
    c_sw_raise: cover property (@(posedge clock) disable iff (srst)
        wr_tmf && sfr.wdata[0] ##2 irq_out.req && irq_out.vector == 16'h0033);

endmodule

// ===== inc/fourlic_pkg.sv
// Constants, register map and carrier types of the four-level interrupt controller.
// Assumes an SFR-style byte port from the processor core, one clock, synchronous reset.
package fourlic_pkg;

    // ============================================================
    // Sizes
    localparam int NSRC = 15;
    localparam int NLVL = 4;

    // ============================================================
    // SFR offsets
    localparam logic [7:0] OFF_ENABLE_REG_FIRST = 8'ha8;
    localparam logic [7:0] OFF_ENABLE_REG_SECOND = 8'he8;
    localparam logic [7:0] OFF_IP0  = 8'hb8;
    localparam logic [7:0] OFF_PRIORITY_HIGH_GROUP0 = 8'hb7;
    localparam logic [7:0] OFF_IP1  = 8'hf8;
    localparam logic [7:0] OFF_PRIORITY_HIGH_GROUP1 = 8'hf7;
    localparam logic [7:0] OFF_TMF  = 8'hea;
    localparam logic [7:0] OFF_TOVF = 8'heb;
    localparam logic [7:0] OFF_ADCC = 8'hc5;

    // ============================================================
    // Field positions and reset values
    localparam int         GLOBAL_EN_BIT = 7;
    localparam int         CONV_FLAG_BIT = 4;
    localparam int         BYTE_OVF_BIT  = 0;
    localparam logic [7:0] RST_REG       = 8'h00;
    localparam logic [3:0] RST_INSERV    = 4'h0;

    // ============================================================
    // Vectors and polling order (source index = vector slot)
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam logic [3:0] POLL_ORDER [NSRC] = '{
        4'h0, 4'h5, 4'ha, 4'h1, 4'h6, 4'hb, 4'h2, 4'h7,
        4'hc, 4'h3, 4'h8, 4'hd, 4'h4, 4'h9, 4'he};

    // ============================================================
    // Carriers
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fourlic_sfr_t;

    typedef struct packed {
        logic [3:0] capture;
        logic [2:0] compare;
        logic       byte_ovf;
        logic       word_ovf;
        logic       conv_done;
    } fourlic_evt_t;

    typedef struct packed {
        logic        req;
        logic [1:0]  level;
        logic [15:0] vector;
    } fourlic_req_t;

endpackage

// ===== sim/fourlic_core_model.sv
// Behavioural processor core on the far side of the interrupt handshake.
// Assumes the controller's clock and reset; ret_go and slow come from the bench.
module fourlic_core_model
    import fourlic_pkg::*;
(
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         srst,
    // Controller side
    input  wire fourlic_req_t irq_out,
    output logic              irq_ack,
    output logic              irq_ret,
    // Bench control
    input  wire logic         ret_go,
    input  wire logic         slow
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [1:0] wait_cnt;
    wire        ack_due = (wait_cnt == (slow ? 2'h3 : 2'h0));

    // ============================================================
    // Ack only while a vector is shown, promptly or after three cycles
    always_ff @(posedge clock) begin
        if (srst) begin
            irq_ack  <= 1'b0;
            irq_ret  <= 1'b0;
            wait_cnt <= 2'h0;
        end else begin
            irq_ret  <= ret_go;
            irq_ack  <= irq_out.req && !irq_ack && ack_due;
            wait_cnt <= (irq_out.req && !irq_ack && !ack_due) ? wait_cnt + 2'h1 : 2'h0;
        end
    end
endmodule

// ===== sim/testbench.sv
// Self-checking bench for the four-level interrupt controller.
// Assumes fourlic_core and the core model share one 20 MHz clock.
module testbench import fourlic_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    logic         clock, srst, ret_go, slow, irq_ack, irq_ret, rd_d;
    fourlic_sfr_t sfr;
    fourlic_evt_t evt;
    fourlic_req_t irq_out;
    logic [7:0]   sfr_rdata, tf, d;
    logic [5:0]   lv;
    logic [3:0]   in_service;
    logic [31:0]  seed;
    logic [17:0]  rq[$], iq[$];
    int           mismatches, compares, idx;
    logic [7:0]   offs [9] = '{OFF_ENABLE_REG_FIRST, OFF_ENABLE_REG_SECOND, OFF_IP0, OFF_PRIORITY_HIGH_GROUP0, OFF_IP1, OFF_PRIORITY_HIGH_GROUP1,
                               OFF_TMF, OFF_TOVF, OFF_ADCC};
    logic [7:0]   msks [6] = '{8'hff, 8'hff, 8'h7f, 8'h7f, 8'hff, 8'hff};

    fourlic_core dut_u (.clock(clock), .srst(srst), .sfr(sfr), .sfr_rdata(sfr_rdata),
        .external_request_a(lv[0]), .timer0_req(lv[1]), .external_request_b(lv[2]),
        .timer1_req(lv[3]), .uart_req(lv[4]), .twowire_req(lv[5]), .evt(evt),
        .irq_ack(irq_ack), .irq_ret(irq_ret), .irq_out(irq_out), .in_service(in_service));
    fourlic_core_model core_u (.clock(clock), .srst(srst), .irq_out(irq_out),
        .irq_ack(irq_ack), .irq_ret(irq_ret), .ret_go(ret_go), .slow(slow));

    // ============================================================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task automatic cmp(input string name, input logic [17:0] exp, input logic [17:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic results();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock) sfr <= '{1'b1, 1'b0, a, v};
        @(posedge clock) sfr <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        rq.push_back({10'h0, e});
        @(posedge clock) sfr <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clock) sfr <= '0;
    endtask
    task automatic ret();
        @(posedge clock) ret_go <= 1'b1;
        @(posedge clock) ret_go <= 1'b0;
    endtask
    task automatic wait_ack(input logic [1:0] l, input logic [15:0] v, input logic [3:0] isv);
        int n;
        n = 0;
        iq.push_back({l, v});
        do begin
            @(posedge clock);
            n++;
        end while (irq_ack !== 1'b1 && n < 40);
        #1 cmp("in_service", {14'h0, isv}, {14'h0, in_service});
    endtask
    // Software clears flags, the bench drops the six level requests; flags never drop on their own
    task automatic clr(input int i);
        if (i < 6) @(posedge clock) lv[i] <= 1'b0;
        else if (i == 10) wr(OFF_ADCC, 8'h00);
        else begin
            tf[i < 10 ? i - 6 : (i < 14 ? i - 7 : 7)] = 1'b0;
            wr(OFF_TMF, tf);
            if (i == 14) wr(OFF_TOVF, 8'h00);
        end
    endtask

    // ============================================================
    // Clock, watchdog and result monitor
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    initial begin
        #250000;
        mismatches++;
        results();
    end
    always @(posedge clock) begin
        if (rd_d) cmp("sfr_rdata", rq.pop_front(), {10'h0, sfr_rdata});
        if (irq_ack === 1'b1 && irq_out.req === 1'b1)
            cmp("irq_out", iq.size() ? iq.pop_front() : 18'h0, {irq_out.level, irq_out.vector});
        rd_d <= sfr.rd;
    end

    // ============================================================
    // Main sequence
    initial begin
        {srst, sfr, evt, lv, ret_go, slow, tf} = {1'b1, 36'h0, 8'hff};
        seed = 32'd36226;
        repeat (8) @(posedge clock);
        srst <= 1'b0;
        for (int i = 0; i < 9; i++) rd(offs[i], RST_REG);
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            d = seed[7:0];
            wr(offs[i], d);
            rd(offs[i], d & msks[i]);
            wr(offs[i], 8'h00);
        end
        wr(OFF_ADCC, 8'hff);
        rd(OFF_ADCC, 8'h00);
        wr(8'h10, 8'hff);
        rd(8'h10, 8'h00);
        // All fifteen pending at level 0, global enable held off
        wr(OFF_ENABLE_REG_FIRST, 8'h7f);
        wr(OFF_ENABLE_REG_SECOND, 8'hff);
        @(posedge clock) {lv, evt} <= {6'h3f, 10'h3ff};
        @(posedge clock) evt <= '0;
        repeat (10) @(posedge clock);
        cmp("irq_req", 18'h0, {17'h0, irq_out.req});
        rd(OFF_TMF, 8'hff);
        rd(OFF_TOVF, 8'h01);
        rd(OFF_ADCC, 8'h10);
        for (int k = 0; k < NSRC; k++) begin
            idx = POLL_ORDER[k];
            if (k == 0) wr(OFF_ENABLE_REG_FIRST, 8'hff);
            else ret();
            wait_ack(2'h0, VEC_BASE + 16'(idx) * 16'h0008, 4'h1);
            clr(idx);
        end
        ret();
        // Nesting: levels 0..3 on ext0, timer0, ext1, timer1; uart disabled
        slow <= 1'b1;
        wr(OFF_IP0, 8'h0a);
        wr(OFF_PRIORITY_HIGH_GROUP0, 8'h0c);
        wr(OFF_ENABLE_REG_FIRST, 8'h8f);
        @(posedge clock) lv <= 6'h11;
        wait_ack(2'h0, 16'h0003, 4'h1);
        @(posedge clock) lv[3] <= 1'b1;
        wait_ack(2'h3, 16'h001b, 4'h9);
        @(posedge clock) lv[2:1] <= 2'h3;
        repeat (8) @(posedge clock);
        clr(3);
        ret();
        wait_ack(2'h2, 16'h0013, 4'h5);
        clr(2);
        ret();
        wait_ack(2'h1, 16'h000b, 4'h3);
        clr(1);
        ret();
        clr(0);
        ret();
        // Software raises capture 0 the way the hardware would
        wr(OFF_TMF, 8'h01);
        wait_ack(2'h0, 16'h0033, 4'h1);
        clr(6);
        ret();
        lv[4] <= 1'b0;
        repeat (4) @(posedge clock);
        cmp("in_service", 18'h0, {14'h0, in_service});
        results();
    end
endmodule
